// File: src/adc_conversion_start_control.sv
// converter start control with axi4-lite register slave
// Function
// - normal mode tracks except while converting
// - done flag sticky until software clears
// - busy high while converting or in timed low power tracking, done on fall
// - window flag sticky until software clears
// - low power software start, 3 clock track
// - low power timer0 start, 3 clock track
// - low power timer2 start, 3 clock track
// - low power timer1 start, 3 clock track
// - low power timer3 start, 3 clock track
// - low power pin: track low, convert rise
// - codes 11x start nothing
`timescale 1ns/1ps
module adc_conversion_start_control #(
  parameter logic [7:0] SAR_DIV = adc_conversion_start_control_pkg::SAR_DIV_RESET
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        timer0_overflow,
  input  wire logic        timer1_overflow,
  input  wire logic        timer2_overflow,
  input  wire logic        timer3_overflow,
  input  wire logic        external_convert_start,
  input  wire logic        conversion_complete,
  input  wire logic        window_compare_match,
  output logic             converter_power,
  output logic             converter_track,
  output logic             converter_start,
  output logic             irq
);
  localparam logic [7:0] SAR_DIV_LAST = SAR_DIV - 8'h01;

  logic [7:0]  aw_addr;
  logic        aw_held;
  logic [31:0] w_data;
  logic        w_lane0;
  logic        w_held;
  logic        do_write;
  logic        hit_control;
  logic        hit_status;
  logic        hit_mask;
  logic        converter_enable;
  logic        track_mode_select;
  logic        conversion_done_flag;
  logic        window_match_flag;
  logic [2:0]  start_source_select;
  logic [1:0]  irq_mask;
  logic        pin_prev;
  logic        pin_rise;
  logic        busy_write;
  logic        trigger;
  logic        conversion_busy;
  logic        convert_done_event;
  logic [7:0]  sar_div_count;
  logic        sar_tick;
  logic [3:0]  track_count;
  adc_conversion_start_control_pkg::conv_state_t state;

  // address and data may arrive in either order; each is held until both are present
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid) && !s_axi_bvalid;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_byte;
  logic        wr_lane;
  assign wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  assign wr_byte = w_held ? w_data[7:0] : s_axi_wdata[7:0];
  assign wr_lane = w_held ? w_lane0 : s_axi_wstrb[0];
  // only the word index is decoded; byte offsets inside a word alias to it
  assign hit_control = wr_addr[7:2] == adc_conversion_start_control_pkg::CONTROL_OFFSET[7:2];
  assign hit_status  = wr_addr[7:2] == adc_conversion_start_control_pkg::IRQ_STATUS_OFFSET[7:2];
  assign hit_mask    = wr_addr[7:2] == adc_conversion_start_control_pkg::IRQ_MASK_OFFSET[7:2];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      w_held  <= 1'b0;
      w_data  <= 32'h00000000;
      w_lane0 <= 1'b0;
    end else if (do_write) begin
      w_held <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held  <= 1'b1;
      w_data  <= s_axi_wdata;
      w_lane0 <= s_axi_wstrb[0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= adc_conversion_start_control_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (hit_control || hit_status || hit_mask) ?
                      adc_conversion_start_control_pkg::RESP_OKAY :
                      adc_conversion_start_control_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic ctl_we;
  logic status_we;
  assign ctl_we    = do_write && hit_control && wr_lane;
  assign status_we = do_write && hit_status && wr_lane;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      converter_enable    <= adc_conversion_start_control_pkg::CONTROL_RESET[7];
      track_mode_select   <= adc_conversion_start_control_pkg::CONTROL_RESET[6];
      start_source_select <= adc_conversion_start_control_pkg::CONTROL_RESET[2:0];
    end else if (ctl_we) begin
      converter_enable    <= wr_byte[adc_conversion_start_control_pkg::ENABLE_BIT];
      track_mode_select   <= wr_byte[adc_conversion_start_control_pkg::TRACK_BIT];
      start_source_select <= wr_byte[2:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_mask <= 2'h0;
    end else if (do_write && hit_mask && wr_lane) begin
      irq_mask <= {wr_byte[adc_conversion_start_control_pkg::DONE_BIT],
                   wr_byte[adc_conversion_start_control_pkg::WINDOW_BIT]};
    end
  end

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      conversion_done_flag <= 1'b0;
    end else if (convert_done_event) begin
      conversion_done_flag <= 1'b1;
    end else if (ctl_we && !wr_byte[adc_conversion_start_control_pkg::DONE_BIT]) begin
      conversion_done_flag <= 1'b0;
    end else if (status_we && wr_byte[adc_conversion_start_control_pkg::DONE_BIT]) begin
      conversion_done_flag <= 1'b0;
    end
  end

  // the window result is only latched together with a completed conversion
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      window_match_flag <= 1'b0;
    end else if (convert_done_event && window_compare_match) begin
      window_match_flag <= 1'b1;
    end else if (ctl_we && !wr_byte[adc_conversion_start_control_pkg::WINDOW_BIT]) begin
      window_match_flag <= 1'b0;
    end else if (status_we && wr_byte[adc_conversion_start_control_pkg::WINDOW_BIT]) begin
      window_match_flag <= 1'b0;
    end
  end

  // level interrupt: stays high until every unmasked flag is cleared
  assign irq = |({conversion_done_flag, window_match_flag} & irq_mask);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= adc_conversion_start_control_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= adc_conversion_start_control_pkg::RESP_OKAY;
      if (s_axi_araddr[7:2] == adc_conversion_start_control_pkg::CONTROL_OFFSET[7:2]) begin
        s_axi_rdata <= {24'h000000, converter_enable, track_mode_select, conversion_done_flag,
                        conversion_busy, window_match_flag, start_source_select};
      end else if (s_axi_araddr[7:2] == adc_conversion_start_control_pkg::IRQ_STATUS_OFFSET[7:2])
      begin
        s_axi_rdata <= {26'h0000000, conversion_done_flag, 1'b0, window_match_flag, 3'h0};
      end else if (s_axi_araddr[7:2] == adc_conversion_start_control_pkg::IRQ_MASK_OFFSET[7:2])
      begin
        s_axi_rdata <= {26'h0000000, irq_mask[1], 1'b0, irq_mask[0], 3'h0};
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= adc_conversion_start_control_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // one read at a time: no new address is taken while read data waits
  assign s_axi_arready = !s_axi_rvalid;

  // the pin idles low, so a cleared history after reset gives no false edge
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pin_prev <= 1'b0;
    end else begin
      pin_prev <= external_convert_start;
    end
  end
  assign pin_rise = external_convert_start && !pin_prev;

  // a write of zero to the busy bit does nothing
  assign busy_write = ctl_we && wr_byte[adc_conversion_start_control_pkg::BUSY_BIT];

  // codes 11x fall to the default branch and start nothing
  always_comb begin
    case (start_source_select)
      adc_conversion_start_control_pkg::SRC_SOFTWARE: trigger = busy_write;
      adc_conversion_start_control_pkg::SRC_TIMER0:   trigger = timer0_overflow;
      adc_conversion_start_control_pkg::SRC_TIMER2:   trigger = timer2_overflow;
      adc_conversion_start_control_pkg::SRC_TIMER1:   trigger = timer1_overflow;
      adc_conversion_start_control_pkg::SRC_TIMER3:   trigger = timer3_overflow;
      adc_conversion_start_control_pkg::SRC_PIN:      trigger = pin_rise;
      default:                                        trigger = 1'b0;
    endcase
  end

  // sar clock is a divided tick; tracking length is counted in these ticks
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sar_div_count <= 8'h00;
    end else if (state != adc_conversion_start_control_pkg::ST_TRACK) begin
      sar_div_count <= 8'h00;
    end else if (sar_div_count == SAR_DIV_LAST) begin
      sar_div_count <= 8'h00;
    end else begin
      sar_div_count <= sar_div_count + 8'h01;
    end
  end
  assign sar_tick = state == adc_conversion_start_control_pkg::ST_TRACK &&
                    sar_div_count == SAR_DIV_LAST;

  // decoded once so the track output falls on the same edge that starts a conversion
  logic        track_done;
  logic        start_track;
  logic        start_convert;
  assign track_done    = sar_tick &&
                         track_count == adc_conversion_start_control_pkg::TRACK_SAR_CLOCKS - 4'h1;
  assign start_track   = converter_enable && trigger && track_mode_select &&
                         state == adc_conversion_start_control_pkg::ST_IDLE &&
                         start_source_select != adc_conversion_start_control_pkg::SRC_PIN;
  assign start_convert = converter_enable && !start_track && (track_done ||
                         (trigger && state == adc_conversion_start_control_pkg::ST_IDLE));

  // a cleared enable bit aborts tracking or conversion at the next edge
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= adc_conversion_start_control_pkg::ST_IDLE;
    end else if (!converter_enable) begin
      state <= adc_conversion_start_control_pkg::ST_IDLE;
    end else begin
      case (state)
        adc_conversion_start_control_pkg::ST_IDLE: begin
          if (start_track) begin
            state <= adc_conversion_start_control_pkg::ST_TRACK;
          end else if (start_convert) begin
            state <= adc_conversion_start_control_pkg::ST_CONVERT;
          end
        end
        adc_conversion_start_control_pkg::ST_TRACK: begin
          if (track_done) begin
            state <= adc_conversion_start_control_pkg::ST_CONVERT;
          end
        end
        adc_conversion_start_control_pkg::ST_CONVERT: begin
          if (conversion_complete) begin
            state <= adc_conversion_start_control_pkg::ST_IDLE;
          end
        end
        default: state <= adc_conversion_start_control_pkg::ST_IDLE;
      endcase
    end
  end

  // counts sar ticks of one tracking phase; cleared on every entry to it
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      track_count <= 4'h0;
    end else if (start_track) begin
      track_count <= 4'h0;
    end else if (sar_tick) begin
      track_count <= track_count + 4'h1;
    end
  end

  assign conversion_busy    = state != adc_conversion_start_control_pkg::ST_IDLE;
  assign convert_done_event = converter_enable && conversion_complete &&
                              state == adc_conversion_start_control_pkg::ST_CONVERT;

  // power and track outputs to the analog core are registered to keep them glitch free; start is decoded from the state register
  logic next_track;
  always_comb begin
    if (!converter_enable || start_convert ||
        state == adc_conversion_start_control_pkg::ST_CONVERT) begin
      next_track = 1'b0;
    end else if (start_track) begin
      next_track = 1'b1;
    end else if (!track_mode_select) begin
      next_track = 1'b1;
    end else if (start_source_select == adc_conversion_start_control_pkg::SRC_PIN) begin
      next_track = !external_convert_start;
    end else begin
      next_track = state == adc_conversion_start_control_pkg::ST_TRACK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      converter_power <= 1'b0;
      converter_track <= 1'b0;
    end else begin
      converter_power <= converter_enable;
      converter_track <= next_track;
    end
  end
  assign converter_start = state == adc_conversion_start_control_pkg::ST_CONVERT;
endmodule : adc_conversion_start_control

// File: src/adc_conversion_start_control_pkg.sv
// constants for the converter start control block
package adc_conversion_start_control_pkg;
  localparam logic [7:0] CONTROL_OFFSET    = 8'hE8;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'hF0;
  localparam logic [7:0] IRQ_MASK_OFFSET   = 8'hF4;
  localparam logic [7:0] CONTROL_RESET     = 8'h00;
  localparam int ENABLE_BIT  = 7;
  localparam int TRACK_BIT   = 6;
  localparam int DONE_BIT    = 5;
  localparam int BUSY_BIT    = 4;
  localparam int WINDOW_BIT  = 3;
  localparam logic [2:0] SRC_SOFTWARE = 3'h0;
  localparam logic [2:0] SRC_TIMER0   = 3'h1;
  localparam logic [2:0] SRC_TIMER2   = 3'h2;
  localparam logic [2:0] SRC_TIMER1   = 3'h3;
  localparam logic [2:0] SRC_PIN      = 3'h4;
  localparam logic [2:0] SRC_TIMER3   = 3'h5;
  localparam logic [3:0] TRACK_SAR_CLOCKS = 4'h3;
  localparam logic [7:0] SAR_DIV_RESET    = 8'h04;
  localparam logic [1:0] RESP_OKAY        = 2'h0;
  localparam logic [1:0] RESP_SLVERR      = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_TRACK,
    ST_CONVERT
  } conv_state_t;
endpackage : adc_conversion_start_control_pkg

// File: tb/adc_start_monitor.sv
// port-level assertions for the converter start control block
`timescale 1ns/1ps
module adc_start_monitor (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        conversion_complete,
  input wire logic        converter_power,
  input wire logic        converter_track,
  input wire logic        converter_start,
  input wire logic        irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic mapped;
  assign mapped = s_axi_araddr inside {8'hE8, 8'hF0, 8'hF4};
  track_excl_start_a: assert property (!(converter_start && converter_track))
    else $error("track and start high together");
  // power lags the enable bit by one cycle, so the first busy cycle is exempt
  start_needs_power_a: assert property (
    converter_start && $past(converter_start) |-> converter_power)
    else $error("conversion while powered down");
  busy_holds_a: assert property (
    converter_start && !conversion_complete && !s_axi_wvalid |=> converter_start)
    else $error("busy dropped before completion");
  busy_falls_a: assert property (converter_start && conversion_complete |=> !converter_start)
    else $error("busy held after completion");
  irq_sticky_a: assert property (irq && !s_axi_wvalid && !s_axi_awvalid |=> irq)
    else $error("interrupt dropped without a write");
  irq_cause_a: assert property (
    $rose(irq) |-> $past(conversion_complete) || $past(s_axi_wvalid) || $past(s_axi_awvalid))
    else $error("interrupt rose without cause");
  write_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response missing");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && !mapped
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  cover property (converter_start && conversion_complete);
  cover property (converter_track ##1 converter_start);
  cover property ($rose(irq));
endmodule : adc_start_monitor
bind adc_conversion_start_control adc_start_monitor i_adc_start_monitor (.*);

// File: tb/sar_far_side.sv
// far side model: timers, convert-start pin and converter core
`timescale 1ns/1ps
module sar_far_side (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       converter_start,
  input  wire logic [3:0] fire,
  input  wire logic       pin_req,
  input  wire logic       match_req,
  input  wire logic [7:0] conv_len,
  output logic            timer0_overflow,
  output logic            timer1_overflow,
  output logic            timer2_overflow,
  output logic            timer3_overflow,
  output logic            external_convert_start,
  output logic            conversion_complete,
  output logic            window_compare_match
);
  logic [7:0] cnt;
  always_ff @(posedge sys_clk) begin
    {timer3_overflow, timer2_overflow, timer1_overflow, timer0_overflow} <= fire;
    external_convert_start <= pin_req;
  end
  // the match level toggles outside completion so a stale value is never trusted
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt <= 8'h00;
      conversion_complete <= 1'b0;
      window_compare_match <= 1'b0;
    end else begin
      conversion_complete <= converter_start && !conversion_complete && cnt == conv_len;
      window_compare_match <= (cnt == conv_len) ? match_req : ~window_compare_match;
      cnt <= (converter_start && cnt != conv_len) ? cnt + 8'h01 : 8'h00;
    end
  end
endmodule : sar_far_side

// File: tb/testbench.sv
// self-checking bench for the converter start control block
`timescale 1ns/1ps
module testbench;
  localparam int SD = 2;
  localparam logic [7:0] CTL = 8'hE8;
  localparam logic [1:0] ERR = adc_conversion_start_control_pkg::RESP_SLVERR;
  logic        sys_clk = 1'b0, rst_n = 1'b0, prev_start = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, conv_len = 8'h08;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF, fire = 4'h0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, pin_req = 0, match_req = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        timer0_overflow, timer1_overflow, timer2_overflow, timer3_overflow;
  logic        external_convert_start, conversion_complete, window_compare_match;
  logic        converter_power, converter_track, converter_start;
  int          miscompares = 0, samples_checked = 0, cyc = 0, seed = 32'hA2911611;
  logic [1:0]  wq[$];
  logic [33:0] rq[$];
  int          sq[$];
  adc_conversion_start_control #(.SAR_DIV(8'(SD))) i_adc_conversion_start_control (.*);
  sar_far_side i_sar_far_side (.*);
  always #5 sys_clk = ~sys_clk;
  task automatic chk_resp(input logic [1:0] exp, input logic [1:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error bresp expected %h seen %h", exp, got);
    end
  endtask : chk_resp
  task automatic chk_read(input logic [33:0] exp, input logic [33:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error rdata expected %h seen %h", exp, got);
    end
  endtask : chk_read
  task automatic chk_start(input int exp, input int got);
    samples_checked++;
    if (got != exp) begin
      miscompares++;
      $display("Error start cycle expected %0d seen %0d", exp, got);
    end
  endtask : chk_start
  task automatic chk_level(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_level
  task automatic close_out;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (s_axi_bvalid && s_axi_bready) chk_resp(wq.pop_front(), s_axi_bresp);
    if (s_axi_rvalid && s_axi_rready) chk_read(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (converter_start && !prev_start)
      chk_start((sq.size() > 0) ? sq.pop_front() : 0, cyc);
    prev_start = converter_start;
  end
  // lat below zero means the write starts nothing
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r, input int lat);
    logic ha, hw, hb;
    @(posedge sys_clk);
    wq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    hb = 1'b0;
    while (!hb) begin
      @(negedge sys_clk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      if (ha && hw && lat >= 0) sq.push_back(cyc + 2 + lat);
      @(posedge sys_clk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hb) s_axi_bready <= 1'b0;
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    logic hr, hv;
    @(posedge sys_clk);
    rq.push_back({r, 24'h0, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    hv = 1'b0;
    while (!hv) begin
      @(negedge sys_clk);
      hr = s_axi_arvalid && s_axi_arready;
      hv = s_axi_rvalid;
      @(posedge sys_clk);
      if (hr) s_axi_arvalid <= 1'b0;
      if (hv) s_axi_rready <= 1'b0;
    end
  endtask : rd
  // bit 4 is the pin level, bits 3:0 the timer overflows
  task automatic pulse(input logic [4:0] m, input int lat);
    @(negedge sys_clk);
    if (lat >= 0) sq.push_back(cyc + 4 + lat);
    @(posedge sys_clk);
    fire <= m[3:0];
    pin_req <= m[4];
    @(posedge sys_clk);
    fire <= 4'h0;
    pin_req <= 1'b0;
  endtask : pulse
  task automatic run_one(input logic tm, input logic [2:0] code);
    logic [7:0] cfg;
    logic [4:0] sel;
    int lat;
    cfg = {1'b1, tm, 3'b000, code};
    sel = (code == 1) ? 5'h01 : (code == 2) ? 5'h04 : (code == 3) ? 5'h02 :
          (code == 4) ? 5'h10 : (code == 5) ? 5'h08 : 5'h00;
    lat = (tm && code != 3'h4) ? 3 * SD : 0;
    match_req <= 1'($random(seed));
    conv_len <= 8'h08 + 8'($random(seed) & 15);
    pin_req <= 1'b0;
    wr(CTL, cfg, 2'h0, -1);
    repeat (3) @(negedge sys_clk);
    chk_level("power", 1'b1, converter_power);
    chk_level("track", !tm || code == 3'h4, converter_track);
    pulse(~sel, -1);
    repeat (12) @(negedge sys_clk);
    if (code > 3'h5) begin
      rd(CTL, cfg, 2'h0);
      return;
    end
    if (code == 3'h0) wr(CTL, cfg | 8'h10, 2'h0, lat);
    else pulse(sel, lat);
    while (!converter_start) @(negedge sys_clk);
    if (code == 3'h0) wr(CTL, cfg | 8'h10, 2'h0, -1);
    else pulse(sel, -1);
    while (converter_start) @(negedge sys_clk);
    rd(CTL, cfg | 8'h20 | (match_req ? 8'h08 : 8'h00), 2'h0);
  endtask : run_one
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(CTL, 8'h00, 2'h0);
    rd(8'h10, 8'h00, ERR);
    wr(8'h10, 8'hFF, ERR, -1);
    for (int m = 0; m < 17; m++) run_one(m[3], m[2:0]);
    wr(8'hF4, 8'h28, 2'h0, -1);
    @(negedge sys_clk);
    chk_level("irq", 1'b1, irq);
    wr(8'hF4, 8'h00, 2'h0, -1);
    @(negedge sys_clk);
    chk_level("irq", 1'b0, irq);
    wr(8'hF4, 8'h28, 2'h0, -1);
    wr(8'hF0, 8'h28, 2'h0, -1);
    @(negedge sys_clk);
    chk_level("irq", 1'b0, irq);
    rd(8'hF0, 8'h00, 2'h0);
    wr(CTL, 8'h00, 2'h0, -1);
    repeat (3) @(negedge sys_clk);
    chk_level("power", 1'b0, converter_power);
    chk_level("track", 1'b0, converter_track);
    close_out;
  end
  initial begin
    #100000;
    miscompares++;
    close_out;
  end
endmodule : testbench
